// file: mefl_pkg.sv
// shared constants and types of the motion event buffer logic
package mefl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [5:0] ADDR_ACT_THR   = 6'h24;
  localparam logic [5:0] ADDR_INACT_THR = 6'h25;
  localparam logic [5:0] ADDR_INACT_TIM = 6'h26;
  localparam logic [5:0] ADDR_AXIS_EN   = 6'h27;
  localparam logic [5:0] ADDR_FF_THR    = 6'h28;
  localparam logic [5:0] ADDR_FF_TIM    = 6'h29;
  localparam logic [5:0] ADDR_RATE      = 6'h2c;
  localparam logic [5:0] ADDR_INT_EN    = 6'h2e;
  localparam logic [5:0] ADDR_INT_MAP   = 6'h2f;
  localparam logic [5:0] ADDR_INT_SRC   = 6'h30;
  localparam logic [5:0] ADDR_FORMAT    = 6'h31;
  localparam logic [5:0] ADDR_X0        = 6'h32;
  localparam logic [5:0] ADDR_X1        = 6'h33;
  localparam logic [5:0] ADDR_Y0        = 6'h34;
  localparam logic [5:0] ADDR_Y1        = 6'h35;
  localparam logic [5:0] ADDR_Z0        = 6'h36;
  localparam logic [5:0] ADDR_Z1        = 6'h37;
  localparam logic [5:0] ADDR_BUF_CTL   = 6'h38;
  localparam logic [5:0] ADDR_BUF_STAT  = 6'h39;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int MODE_HI      = 7;
  localparam int MODE_LO      = 6;
  localparam int TSEL_BIT     = 5;
  localparam int SAMP_HI      = 4;
  localparam int ACT_AC_BIT   = 7;
  localparam int ACT_EN_HI    = 6;
  localparam int ACT_EN_LO    = 4;
  localparam int INACT_AC_BIT = 3;
  localparam int INACT_EN_HI  = 2;
  localparam int INACT_EN_LO  = 0;
  localparam int INV_BIT      = 5;
  localparam int SRC_W        = 5;
  localparam int STAT_TRIG    = 7;

  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h0a;

  ////////////////////////////////////////////////////////////////////////////
  // timing: free-fall time base and inactivity seconds
  localparam int CLK_MHZ        = 125;
  localparam int FF_LSB_US      = 5000;
  localparam int FF_TICK_CYCLES = FF_LSB_US * CLK_MHZ;
  localparam int INACT_LSB_MS   = 1000;
  localparam int INACT_TICKS    = INACT_LSB_MS * 1000 / FF_LSB_US;
  localparam int MAG_SHIFT      = 4;
  localparam int BUF_DEPTH      = 32;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } mefl_sample_t;

  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_END} mefl_op_t;

  typedef struct packed {
    mefl_op_t    op;
    logic [5:0]  addr;
    logic [7:0]  wdata;
  } mefl_req_t;

  typedef enum logic [1:0] {
    MODE_BYPASS, MODE_FIFO, MODE_STREAM, MODE_TRIGGER
  } mefl_mode_t;

  typedef enum logic {LNK_IDLE, LNK_BUSY} mefl_lnk_state_t;

endpackage

// file: mefl_sync.sv
// three-stage level synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module mefl_sync
  import mefl_pkg::*;
(
  // destination clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // level from the other domain
  input  wire logic d,
  // accepted level
  output logic      q
);

  logic s1;
  logic s2;
  logic s3;

  // s1 is seen only by s2; q moves once s2 and s3 agree
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q  <= 1'b0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        q <= s3;
    end
  end

endmodule
`default_nettype wire

// file: mefl_top.sv
// motion event flags and 32-entry sample buffer with register port
// Operation
// - activity flag sets when an enabled axis magnitude exceeds threshold
// - inactivity sets when enabled axes stay under threshold past time
// - free-fall sets when all axes stay under threshold past time
// - free-fall always uses all three axes, dc values only
// - watermark sets when stored count equals sample-count field
// - watermark clears once reads drop count below sample-count
// - bypass overrun when a new sample replaces unread output data
// - other modes overrun when buffer becomes full
// - overrun clears when buffer contents are read
// - mode is control bits 7:6; bypass keeps buffer empty
// - fill-and-stop stores until 32 entries, then stops storing
// - watermark holds while count is not below sample-count
// - stream keeps newest 32, dropping oldest when full
// - trigger keeps newest 32, then last n, then fill-and-stop
// - trigger is the interrupt on the output chosen by select bit
// - one trigger only until re-armed through bypass
// - data reads return buffered entries; pop brings next oldest
// - single-byte read loses the rest of that entry
// - event flags latch; source read clears non-data flags
// - enabled events drive output a or b per mapping bit
`timescale 1ns/1ps
`default_nettype none
module mefl_top
  import mefl_pkg::*;
#(
  parameter int DEPTH       = BUF_DEPTH,
  parameter int TICK_CYCLES = FF_TICK_CYCLES
)
(
  // system clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // sample source, same clock
  input  wire logic         sample_valid,
  input  wire mefl_sample_t sample,
  // register port on the link clock
  input  wire logic         clk_link,
  input  wire logic         lnk_req,
  input  wire mefl_req_t    lnk_cmd,
  output logic              lnk_ready,
  output logic              lnk_rvalid,
  output logic [7:0]        lnk_rdata,
  // interrupt outputs
  output logic              irq_out_a,
  output logic              irq_out_b
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int TW = $clog2(TICK_CYCLES);

  function automatic logic [15:0] mefl_mag(input logic [15:0] v);
    logic [15:0] a;
    a = v[15] ? (~v + 16'h0001) : v;
    return a >> MAG_SHIFT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link domain: reset release, request hold, toggle handshake
  logic            lnk_rst_q1;
  logic            lnk_rst_b;
  mefl_lnk_state_t lnk_state;
  mefl_req_t       hold;
  logic            req_tgl;
  logic            ack_sync;
  logic            ack_seen;
  logic            ack_tgl;
  logic [7:0]      rdata_sys;

  // reset synchroniser into the link clock
  always_ff @(posedge clk_link)
  begin
    lnk_rst_q1 <= rst_b;
    lnk_rst_b  <= lnk_rst_q1;
  end

  wire lnk_take = lnk_req && lnk_ready;
  wire ack_evt  = ack_sync != ack_seen;
  assign lnk_ready = lnk_state == LNK_IDLE;

  // hold stays frozen while busy, so the word crossing is safe
  always_ff @(posedge clk_link)
  begin
    if (!lnk_rst_b)
    begin
      lnk_state <= LNK_IDLE;
      hold      <= '0;
      req_tgl   <= 1'b0;
      ack_seen  <= 1'b0;
    end
    else
    begin
      ack_seen <= ack_sync;
      if (lnk_take)
      begin
        hold      <= lnk_cmd;
        req_tgl   <= ~req_tgl;
        lnk_state <= LNK_BUSY;
      end
      else if (ack_evt)
        lnk_state <= LNK_IDLE;
    end
  end

  // read answer taken over from the system side
  always_ff @(posedge clk_link)
  begin
    if (!lnk_rst_b)
    begin
      lnk_rvalid <= 1'b0;
      lnk_rdata  <= 8'h00;
    end
    else
    begin
      lnk_rvalid <= ack_evt && hold.op == OP_READ;
      if (ack_evt)
        lnk_rdata <= rdata_sys;
    end
  end

  mefl_sync u_ack_sync (
    .clk   (clk_link),
    .rst_b (lnk_rst_b),
    .d     (ack_tgl),
    .q     (ack_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // system side request decode
  logic req_sync;
  logic req_seen;

  mefl_sync u_req_sync (
    .clk   (clk_sys),
    .rst_b (rst_b),
    .d     (req_tgl),
    .q     (req_sync)
  );

  wire req_evt   = req_sync != req_seen;
  wire is_rd     = req_evt && hold.op == OP_READ;
  wire is_wr     = req_evt && hold.op == OP_WRITE;
  wire data_rd   = is_rd && hold.addr >= ADDR_X0 && hold.addr <= ADDR_Z1;
  wire src_clr   = is_rd && hold.addr == ADDR_INT_SRC;
  logic read_open;
  // a data burst ends on any other access or on frame end
  wire pop_req   = read_open && req_evt && !data_rd;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [7:0] thr_act, thr_inact, t_inact, axis_en;
  logic [7:0] thr_ff, t_ff, rate, int_en, int_map, fmt, buf_ctl;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      thr_act <= RST_ZERO; thr_inact <= RST_ZERO; t_inact <= RST_ZERO;
      axis_en <= RST_ZERO; thr_ff    <= RST_ZERO; t_ff    <= RST_ZERO;
      rate    <= RST_RATE; int_en    <= RST_ZERO; int_map <= RST_ZERO;
      fmt     <= RST_ZERO; buf_ctl   <= RST_ZERO;
    end
    else if (is_wr)
    begin
      unique case (hold.addr)
        ADDR_ACT_THR:   thr_act   <= hold.wdata;
        ADDR_INACT_THR: thr_inact <= hold.wdata;
        ADDR_INACT_TIM: t_inact   <= hold.wdata;
        ADDR_AXIS_EN:   axis_en   <= hold.wdata;
        ADDR_FF_THR:    thr_ff    <= hold.wdata;
        ADDR_FF_TIM:    t_ff      <= hold.wdata;
        ADDR_RATE:      rate      <= hold.wdata;
        ADDR_INT_EN:    int_en    <= hold.wdata;
        ADDR_INT_MAP:   int_map   <= hold.wdata;
        ADDR_FORMAT:    fmt       <= hold.wdata;
        ADDR_BUF_CTL:   buf_ctl   <= hold.wdata;
        default:        ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-axis comparisons; index 2 is x, 0 is z
  logic [15:0] axis_now  [3];
  logic [15:0] axis_prev [3];
  logic [15:0] axis_dif  [3];
  logic [2:0]  act_over;
  logic [2:0]  inact_under;
  logic [2:0]  ff_under;
  mefl_sample_t prev_smp;

  assign axis_now[2]  = sample.x;
  assign axis_now[1]  = sample.y;
  assign axis_now[0]  = sample.z;
  assign axis_prev[2] = prev_smp.x;
  assign axis_prev[1] = prev_smp.y;
  assign axis_prev[0] = prev_smp.z;

  // ac coupling uses the step from the previous sample
  for (genvar i = 0; i < 3; i++)
  begin : g_axis
    assign axis_dif[i]    = axis_now[i] - axis_prev[i];
    assign act_over[i]    = mefl_mag(axis_en[ACT_AC_BIT] ? axis_dif[i]
                            : axis_now[i]) > {8'h00, thr_act};
    assign inact_under[i] = mefl_mag(axis_en[INACT_AC_BIT] ? axis_dif[i]
                            : axis_now[i]) < {8'h00, thr_inact};
    assign ff_under[i]    = mefl_mag(axis_now[i]) < {8'h00, thr_ff};
  end

  wire [2:0] act_ax   = axis_en[ACT_EN_HI:ACT_EN_LO];
  wire [2:0] inact_ax = axis_en[INACT_EN_HI:INACT_EN_LO];
  wire act_hit   = |(act_ax & act_over);
  wire inact_all = (|inact_ax) && (&(~inact_ax | inact_under));
  wire ff_all    = &ff_under;

  ////////////////////////////////////////////////////////////////////////////
  // time base and duration counters
  logic [TW-1:0] tick_cnt;
  logic [15:0]   inact_cnt;
  logic [8:0]    ff_cnt;
  logic          inact_below;
  logic          ff_below;

  wire tick = tick_cnt == TW'(TICK_CYCLES - 1);
  wire [15:0] inact_limit = 16'(32'(t_inact) * INACT_TICKS);
  wire inact_fire = inact_below && inact_cnt > inact_limit;
  wire ff_fire    = ff_below && ff_cnt > {1'b0, t_ff};

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      tick_cnt <= '0;
    else
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
  end

  // below-threshold state is refreshed on every sample
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      prev_smp    <= '0;
      inact_below <= 1'b0;
      ff_below    <= 1'b0;
    end
    else if (sample_valid)
    begin
      prev_smp    <= sample;
      inact_below <= inact_all;
      ff_below    <= ff_all;
    end
  end

  // counters saturate so a long quiet spell cannot wrap and re-arm
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || !inact_below)
      inact_cnt <= '0;
    else if (tick && inact_cnt != '1)
      inact_cnt <= inact_cnt + 1'b1;
    if (!rst_b || !ff_below)
      ff_cnt <= '0;
    else if (tick && ff_cnt != '1)
      ff_cnt <= ff_cnt + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer control
  mefl_sample_t      mem [DEPTH];
  mefl_sample_t      out_reg;
  logic [AW-1:0]     wr_ptr, rd_ptr, next_wr, next_rd;
  logic [CW-1:0]     count, next_count;
  logic              triggered;
  logic              unread;
  logic              trig_prev;
  logic              lvl_a, lvl_b;

  wire mefl_mode_t mode = mefl_mode_t'(buf_ctl[MODE_HI:MODE_LO]);
  wire [CW-1:0] keep_n  = CW'(buf_ctl[SAMP_HI:0]);
  wire bypass    = mode == MODE_BYPASS;
  wire fill_stop = mode == MODE_FIFO || (mode == MODE_TRIGGER && triggered);
  wire full      = count == CW'(DEPTH);
  wire pop_do    = pop_req && !bypass && count != '0;
  // fill-and-stop refuses samples while full, unless a pop frees an entry in the same cycle
  wire push      = sample_valid && !bypass
                   && (!fill_stop || !full || pop_do);
  wire drop      = push && full && !fill_stop && !pop_do;
  wire trig_lvl  = buf_ctl[TSEL_BIT] ? lvl_b : lvl_a;
  wire trig_evt  = mode == MODE_TRIGGER && !triggered
                   && trig_lvl && !trig_prev;

  // pointer and count arithmetic; depth must be a power of two
  always_comb
  begin
    next_wr    = wr_ptr + AW'(push);
    next_rd    = rd_ptr + AW'(pop_do || drop);
    next_count = count + CW'(push) - CW'(pop_do) - CW'(drop);
    if (trig_evt && next_count > keep_n)
    begin
      next_count = keep_n;
      next_rd    = next_wr - AW'(keep_n);
    end
    if (bypass)
    begin
      next_wr    = '0;
      next_rd    = '0;
      next_count = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      triggered <= 1'b0;
    end
    else
    begin
      wr_ptr    <= next_wr;
      rd_ptr    <= next_rd;
      count     <= next_count;
      triggered <= !bypass && (triggered || trig_evt);
    end
  end

  // storage has no reset; only pointers define what is valid
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= sample;
  end

  // bypass output registers and their unread marker
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      out_reg <= '0;
      unread  <= 1'b0;
    end
    else
    begin
      if (bypass && sample_valid)
        out_reg <= sample;
      unread <= (bypass && sample_valid) || (unread && !pop_req);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event flags; a set in the clearing cycle wins
  logic act_flag, inact_flag, ff_flag, ovr_flag;

  wire wm_flag = count >= keep_n;
  wire ovr_set = bypass ? (sample_valid && unread)
                 : ((push && next_count == CW'(DEPTH) && !full)
                    || drop);
  wire [SRC_W-1:0] src = {act_flag, inact_flag, ff_flag, wm_flag, ovr_flag};
  wire [SRC_W-1:0] gated = src & int_en[SRC_W-1:0];
  wire raw_a = |(gated & ~int_map[SRC_W-1:0]);
  wire raw_b = |(gated & int_map[SRC_W-1:0]);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      act_flag   <= 1'b0;
      inact_flag <= 1'b0;
      ff_flag    <= 1'b0;
      ovr_flag   <= 1'b0;
    end
    else
    begin
      act_flag   <= (sample_valid && act_hit) || (act_flag && !src_clr);
      inact_flag <= inact_fire || (inact_flag && !src_clr);
      ff_flag    <= ff_fire || (ff_flag && !src_clr);
      ovr_flag   <= ovr_set || (ovr_flag && !pop_req);
    end
  end

  // interrupt outputs and trigger edge; polarity applied last
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      lvl_a     <= 1'b0;
      lvl_b     <= 1'b0;
      trig_prev <= 1'b0;
      irq_out_a <= 1'b0;
      irq_out_b <= 1'b0;
    end
    else
    begin
      lvl_a     <= raw_a;
      lvl_b     <= raw_b;
      trig_prev <= trig_lvl;
      irq_out_a <= raw_a ^ fmt[INV_BIT];
      irq_out_b <= raw_b ^ fmt[INV_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data selection and answer
  wire mefl_sample_t view = bypass ? out_reg : mem[rd_ptr];
  logic [7:0] rd_mux;

  always_comb
  begin
    unique case (hold.addr)
      ADDR_ACT_THR:   rd_mux = thr_act;
      ADDR_INACT_THR: rd_mux = thr_inact;
      ADDR_INACT_TIM: rd_mux = t_inact;
      ADDR_AXIS_EN:   rd_mux = axis_en;
      ADDR_FF_THR:    rd_mux = thr_ff;
      ADDR_FF_TIM:    rd_mux = t_ff;
      ADDR_RATE:      rd_mux = rate;
      ADDR_INT_EN:    rd_mux = int_en;
      ADDR_INT_MAP:   rd_mux = int_map;
      ADDR_INT_SRC:   rd_mux = {3'h0, src};
      ADDR_FORMAT:    rd_mux = fmt;
      ADDR_X0:        rd_mux = view.x[7:0];
      ADDR_X1:        rd_mux = view.x[15:8];
      ADDR_Y0:        rd_mux = view.y[7:0];
      ADDR_Y1:        rd_mux = view.y[15:8];
      ADDR_Z0:        rd_mux = view.z[7:0];
      ADDR_Z1:        rd_mux = view.z[15:8];
      ADDR_BUF_CTL:   rd_mux = buf_ctl;
      ADDR_BUF_STAT:  rd_mux = {triggered, 1'b0, 6'(count)};
      default:        rd_mux = 8'h00;
    endcase
  end

  // answer is registered on the same edge the acknowledge toggle leaves
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      req_seen  <= 1'b0;
      ack_tgl   <= 1'b0;
      rdata_sys <= 8'h00;
      read_open <= 1'b0;
    end
    else
    begin
      req_seen  <= req_sync;
      ack_tgl   <= ack_tgl ^ req_evt;
      read_open <= data_rd || (read_open && !pop_req);
      if (is_rd)
        rdata_sys <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_act_sets: assert property (
    sample_valid && act_hit |=> act_flag)
    else $error("activity flag not set");
  chk_inact_time: assert property (
    inact_fire |=> inact_flag [*1] ##1 (inact_flag || src_clr || $past(src_clr)))
    else $error("inactivity flag not set after time");
  chk_ff_time: assert property (
    ff_below && ff_cnt > {1'b0, t_ff} |=> ff_flag)
    else $error("free-fall flag not set after time");
  chk_ff_axes: assert property (
    sample_valid |=> ff_below == $past(&ff_under))
    else $error("free-fall not using all axes");
  chk_wm_clear: assert property (
    pop_do && !push && count == keep_n && keep_n != '0 |=> !wm_flag)
    else $error("watermark not cleared below level");
  chk_ovr_bypass: assert property (
    bypass && sample_valid && unread |=> ovr_flag)
    else $error("bypass overrun missed");
  chk_ovr_full: assert property (
    !bypass && count == CW'(DEPTH - 1) && push && !pop_do && !trig_evt
    |=> ovr_flag)
    else $error("overrun missed on full buffer");
  chk_bypass_empty: assert property (
    bypass [*2] |-> count == '0)
    else $error("buffer not empty in bypass");
  chk_fill_stop: assert property (
    mode == MODE_FIFO && full && !pop_req ##1 mode == MODE_FIFO
    |-> count == CW'(DEPTH) && $stable(wr_ptr))
    else $error("fill-and-stop stored into a full buffer");
  chk_stream_drop: assert property (
    mode == MODE_STREAM && full && push && !pop_do
    |=> full && rd_ptr == $past(rd_ptr) + 1'b1)
    else $error("stream did not drop oldest");
  chk_trig_keep: assert property (
    trig_evt && !bypass |=> triggered && count <= $past(keep_n) + 1'b1)
    else $error("trigger did not trim to n entries");
  chk_pop_step: assert property (
    pop_do && !push && !trig_evt |=> count == $past(count) - 1'b1)
    else $error("pop did not remove one entry");
  chk_irq_route: assert property (
    ##1 lvl_b == $past(|(src & int_en[SRC_W-1:0] & int_map[SRC_W-1:0])))
    else $error("interrupt routed to wrong output");

  cov_stream_drop: cover property (drop);
  cov_trigger: cover property (trig_evt ##[1:50] pop_do);
  cov_bypass_ovr: cover property (bypass && ovr_set);
  cov_fill_full: cover property (mode == MODE_FIFO && full);

endmodule
`default_nettype wire

// file: mefl_host.sv
// host model driving the register port of the motion buffer
`timescale 1ns/1ps
`default_nettype none
module mefl_host
  import mefl_pkg::*;
(
  // link clock
  input  wire logic clk_link,
  // register port
  output logic      lnk_req,
  output mefl_req_t lnk_cmd,
  input  wire logic lnk_ready
);
  int timeouts = 0;
  initial
  begin
    lnk_req = 1'b0;
    lnk_cmd = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one request held until taken, then a bounded wait for the answer
  task automatic xfer(mefl_op_t op, logic [5:0] a, logic [7:0] d);
    int n;
    @(negedge clk_link);
    lnk_req = 1'b1;
    lnk_cmd = '{op, a, d};
    for (n = 0; n < 16 && lnk_ready !== 1'b1; n++)
      @(negedge clk_link);
    if (n == 16)
      timeouts++;
    @(negedge clk_link);
    lnk_req = 1'b0;
    lnk_cmd = mefl_req_t'(~lnk_cmd); // released lines show no stale value
    // ready may fall one edge late, so skip a cycle before looking
    @(negedge clk_link);
    for (n = 0; n < 16 && lnk_ready !== 1'b1; n++)
      @(negedge clk_link);
    if (n == 16)
      timeouts++;
    // chip select high, then the pop gap
    if (op == OP_END)
      repeat (63) @(negedge clk_link);
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the motion event buffer
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import mefl_pkg::*;
;
  logic         clk_sys      = 1'b0;
  logic         clk_link     = 1'b0;
  logic         rst_b        = 1'b0;
  logic         sample_valid = 1'b0;
  mefl_sample_t sample       = '0;
  logic         lnk_req, lnk_ready, lnk_rvalid, irq_out_a, irq_out_b;
  mefl_req_t    lnk_cmd;
  logic [7:0]   lnk_rdata, thr;
  logic [7:0]   expq[$];
  mefl_sample_t smp[$];
  int           miscompares = 0;
  int           check_count = 0;
  int           i;
  ////////////////////////////////////////////////////////////////////////////
  // clocks: link clock offset so the two never share edges
  always #4 clk_sys = ~clk_sys;
  initial
  begin
    #3;
    forever #40 clk_link = ~clk_link;
  end
  mefl_top #(.DEPTH(32), .TICK_CYCLES(4)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .sample_valid(sample_valid),
    .sample(sample), .clk_link(clk_link), .lnk_req(lnk_req),
    .lnk_cmd(lnk_cmd), .lnk_ready(lnk_ready), .lnk_rvalid(lnk_rvalid),
    .lnk_rdata(lnk_rdata), .irq_out_a(irq_out_a), .irq_out_b(irq_out_b));
  mefl_host u_host (.clk_link(clk_link), .lnk_req(lnk_req),
    .lnk_cmd(lnk_cmd), .lnk_ready(lnk_ready));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    miscompares += u_host.timeouts + expq.size();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(logic [5:0] a, logic [7:0] e);
    expq.push_back(e);
    u_host.xfer(OP_READ, a, 8'h00);
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    u_host.xfer(OP_WRITE, a, d);
  endtask
  task automatic push(mefl_sample_t s);
    smp.push_back(s);
    @(negedge clk_sys);
    sample_valid = 1'b1;
    sample = s;
    @(negedge clk_sys);
    sample_valid = 1'b0;
    sample = mefl_sample_t'(~s);
  endtask
  task automatic fill(int k, logic [15:0] m);
    for (int j = 0; j < k; j++)
      push(mefl_sample_t'(48'({$urandom, $urandom}) & {3{m}}));
  endtask
  // whole entry in one burst; the end of frame pops it
  task automatic burst(mefl_sample_t s);
    for (int k = 0; k < 6; k++)
      rd(ADDR_X0 + 6'(k), s[8*k +: 8]);
    u_host.xfer(OP_END, ADDR_X0, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // read answers are taken off the queue oldest first
  always @(negedge clk_link)
    if (lnk_rvalid === 1'b1)
      chk("lnk_rdata", expq.size() ? expq.pop_front() : 8'hxx, lnk_rdata);
  // hang guard
  initial
  begin
    #500_000;
    miscompares++;
    stop_test();
  end
  // main sequence
  initial
  begin
    i = $urandom(32'h0000_133b);
    repeat (5) @(negedge clk_link);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_link);
    rd(ADDR_BUF_STAT, 8'h00);
    rd(ADDR_INT_SRC, 8'h02);
    rd(ADDR_RATE, 8'h0a);
    rd(6'h10, 8'h00);
    thr = 8'($urandom);
    wr(ADDR_ACT_THR, thr);
    rd(ADDR_ACT_THR, thr);
    wr(ADDR_BUF_STAT, 8'hff);
    rd(ADDR_BUF_STAT, 8'h00);
    fill(2, 16'hffff);
    rd(ADDR_INT_SRC, 8'h03);
    rd(ADDR_BUF_STAT, 8'h00);
    burst(smp[1]);
    rd(ADDR_INT_SRC, 8'h02);
    wr(ADDR_BUF_CTL, 8'h5e);
    smp.delete();
    fill(33, 16'hffff);
    rd(ADDR_BUF_STAT, 8'h20);
    rd(ADDR_INT_SRC, 8'h03);
    burst(smp[0]);
    rd(ADDR_INT_SRC, 8'h02);
    burst(smp[1]);
    rd(ADDR_BUF_STAT, 8'h1e);
    rd(ADDR_X0, smp[2][7:0]);
    u_host.xfer(OP_END, ADDR_X0, 8'h00);
    rd(ADDR_INT_SRC, 8'h00);
    burst(smp[3]);
    wr(ADDR_BUF_CTL, 8'h00);
    wr(ADDR_BUF_CTL, 8'h85);
    smp.delete();
    fill(40, 16'hffff);
    rd(ADDR_BUF_STAT, 8'h20);
    burst(smp[8]);
    wr(ADDR_BUF_CTL, 8'h00);
    wr(ADDR_AXIS_EN, 8'h70);
    wr(ADDR_ACT_THR, 8'h10);
    wr(ADDR_INT_EN, 8'h10);
    wr(ADDR_BUF_CTL, 8'hc4);
    fill(10, 16'h00ff);
    chk("irq_out_a", 8'h00, 8'(irq_out_a));
    push(mefl_sample_t'(48'h0000_0000_7fff));
    repeat (63) @(negedge clk_link);
    chk("irq_out_a", 8'h01, 8'(irq_out_a));
    chk("irq_out_b", 8'h00, 8'(irq_out_b));
    rd(ADDR_BUF_STAT, 8'h84);
    push(mefl_sample_t'(48'h0000_0000_7fff));
    rd(ADDR_BUF_STAT, 8'h85);
    rd(ADDR_INT_SRC, 8'h12);
    repeat (8) @(negedge clk_link);
    chk("irq_out_a", 8'h00, 8'(irq_out_a));
    // re-armed trigger on output b, quiet spell long enough for both timers
    wr(ADDR_BUF_CTL, 8'h00);
    wr(ADDR_INT_MAP, 8'h10);
    wr(ADDR_FF_THR, 8'h10);
    wr(ADDR_FF_TIM, 8'h02);
    wr(ADDR_INACT_THR, 8'h10);
    wr(ADDR_INACT_TIM, 8'h01);
    wr(ADDR_AXIS_EN, 8'h77);
    wr(ADDR_BUF_CTL, 8'he2);
    smp.delete();
    fill(3, 16'h00ff);
    repeat (90) @(negedge clk_link);
    push(mefl_sample_t'(48'h0000_0000_7fff));
    repeat (63) @(negedge clk_link);
    chk("irq_out_b", 8'h01, 8'(irq_out_b));
    chk("irq_out_a", 8'h00, 8'(irq_out_a));
    rd(ADDR_BUF_STAT, 8'h82);
    rd(ADDR_INT_SRC, 8'h1e);
    burst(smp[2]);
    stop_test();
  end
endmodule
`default_nettype wire
